/* cache_control_unit.sv */
// Cache control register with invalidate sweeps, refill and write-miss steering.
// Assumes cache-side inputs come from logic on pclk, so none is synchronised.
//
// Register access over the req/ack link from the APB controller was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module cache_control_unit
	import cache_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// Register access link
	cache_ctl_if.dev                           bus,
	// Instruction cache side
	output logic                               instr_cache_enable,
	output logic [cache_ctl_pkg::NUM_WAYS-1:0] instr_way_refill_inhibit,
	input  wire logic                          instr_activity,
	input  wire logic                          instr_refill_req,
	input  wire logic [1:0]                    instr_refill_way,
	output logic                               instr_refill_grant,
	output logic                               instr_inv_clear,
	output logic [cache_ctl_pkg::IDX_W-1:0]    instr_inv_index,
	// Data cache side
	output logic                               data_cache_enable,
	output logic [cache_ctl_pkg::NUM_WAYS-1:0] data_way_refill_inhibit,
	output logic                               data_write_policy,
	output logic                               data_write_miss_alloc_mode,
	input  wire logic                          data_activity,
	input  wire logic                          data_refill_req,
	input  wire logic [1:0]                    data_refill_way,
	output logic                               data_refill_grant,
	input  wire logic                          data_write_miss,
	output logic                               data_miss_to_cache,
	output logic                               data_miss_to_memory,
	output logic                               data_inv_clear,
	output logic [cache_ctl_pkg::IDX_W-1:0]    data_inv_index,
	// Busy flags as software sees them
	output logic                               instr_cache_busy,
	output logic                               data_cache_busy
);
	import cache_ctl_pkg::*;

	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_ENTRIES - 1);

	logic [15:0]      ctrl_r;
	logic             ack_r;
	logic             err_r;
	logic [15:0]      rdata_r;
	logic             isweep_r;
	logic             dsweep_r;
	logic [IDX_W-1:0] iidx_r;
	logic [IDX_W-1:0] didx_r;
	logic             igrant_r;
	logic             dgrant_r;
	logic             to_cache_r;
	logic             to_mem_r;
	logic             new_req;
	logic             access_ok;
	logic             wr_ok;
	logic             istart;
	logic             dstart;
	logic             ibusy;
	logic             dbusy;
	logic [15:0]      ctrl_view;

	// ==========================================================
	// Helpers
	function automatic logic refill_ok(input logic en, input logic [NUM_WAYS-1:0] mask,
		input logic [1:0] way);
		refill_ok = en & ~mask[way];
	endfunction : refill_ok

	// ==========================================================
	// Access decode
	// A request is taken once; the ack cycle masks the still-held request
	assign new_req   = bus.req && !ack_r;
	assign access_ok = new_req && (bus.addr == CTRL_ADDR) && (bus.size == SIZE_HALF); // RQ1
	assign wr_ok     = access_ok && bus.write;
	assign istart    = wr_ok && bus.wdata[IINV_BIT];                                   // RQ8
	assign dstart    = wr_ok && bus.wdata[DINV_BIT];                                   // RQ7

	// Busy covers both the sweep and any activity reported by the cache itself
	assign ibusy = isweep_r | instr_activity;                                         // RQ10 RQ14
	assign dbusy = dsweep_r | data_activity;                                          // RQ9 RQ14

	always_comb
	begin
		ctrl_view            = ctrl_r & CTRL_STORED;                                   // RQ7 RQ8
		ctrl_view[IBUSY_BIT] = ibusy;                                                  // RQ10
		ctrl_view[DBUSY_BIT] = dbusy;                                                  // RQ9
	end

	// ==========================================================
	// Link answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			ack_r <= new_req;
			err_r <= new_req && !access_ok;                                            // RQ1
			if (access_ok && !bus.write)
				rdata_r <= ctrl_view;
			else if (new_req)
				rdata_r <= 16'h0000;
		end
	end

	assign bus.ack   = ack_r;
	assign bus.err   = err_r;
	assign bus.rdata = rdata_r;

	// ==========================================================
	// Stored control bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= CTRL_RESET;                                                      // RQ11 RQ12
		else if (wr_ok)
			ctrl_r <= bus.wdata & CTRL_STORED;
	end

	assign instr_cache_enable         = ctrl_r[IEN_BIT];                               // RQ12
	assign data_cache_enable          = ctrl_r[DEN_BIT];                               // RQ11
	assign data_write_policy          = ctrl_r[WPOL_BIT];                              // RQ6
	assign data_write_miss_alloc_mode = ctrl_r[ALLOC_BIT];
	assign instr_way_refill_inhibit   = ctrl_r[IWAY_LSB +: NUM_WAYS];                  // RQ3
	assign data_way_refill_inhibit    = ctrl_r[DWAY_LSB +: NUM_WAYS];                  // RQ2

	// ==========================================================
	// Invalidate sweeps, one index in every way per cycle, over every entry of all ways
	// A new invalidate during a sweep restarts it, so no entry is skipped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			isweep_r <= 1'b0;
			iidx_r   <= '0;
		end
		else if (istart)
		begin
			isweep_r <= 1'b1;                                                          // RQ8 RQ14
			iidx_r   <= '0;
		end
		else if (isweep_r)
		begin
			if (iidx_r == LAST_IDX)
				isweep_r <= 1'b0;                                                      // RQ14
			iidx_r <= iidx_r + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dsweep_r <= 1'b0;
			didx_r   <= '0;
		end
		else if (dstart)
		begin
			dsweep_r <= 1'b1;                                                          // RQ7 RQ14
			didx_r   <= '0;
		end
		else if (dsweep_r)
		begin
			if (didx_r == LAST_IDX)
				dsweep_r <= 1'b0;                                                      // RQ14
			didx_r <= didx_r + 1'b1;
		end
	end

	// Each clear pulse wipes the valid flag of one index in every way
	assign instr_inv_clear = isweep_r;                                                 // RQ8
	assign instr_inv_index = iidx_r;
	assign data_inv_clear  = dsweep_r;                                                 // RQ7
	assign data_inv_index  = didx_r;
	assign instr_cache_busy = ibusy;
	assign data_cache_busy  = dbusy;

	// ==========================================================
	// Refill permission; refused while a sweep would race the refill
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			igrant_r <= 1'b0;
			dgrant_r <= 1'b0;
		end
		else
		begin
			igrant_r <= instr_refill_req && !isweep_r
				&& refill_ok(ctrl_r[IEN_BIT], ctrl_r[IWAY_LSB +: NUM_WAYS], instr_refill_way); // RQ3
			dgrant_r <= data_refill_req && !dsweep_r
				&& refill_ok(ctrl_r[DEN_BIT], ctrl_r[DWAY_LSB +: NUM_WAYS], data_refill_way);  // RQ2
		end
	end

	assign instr_refill_grant = igrant_r;
	assign data_refill_grant  = dgrant_r;

	// ==========================================================
	// Write-miss steering: allocate only in write-back with alloc bit clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_cache_r <= 1'b0;
			to_mem_r   <= 1'b0;
		end
		else
		begin
			to_cache_r <= data_write_miss && ctrl_r[DEN_BIT]
				&& !ctrl_r[WPOL_BIT] && !ctrl_r[ALLOC_BIT];                            // RQ4 RQ5 RQ6
			to_mem_r   <= data_write_miss && !(ctrl_r[DEN_BIT]
				&& !ctrl_r[WPOL_BIT] && !ctrl_r[ALLOC_BIT]);                           // RQ4 RQ5
		end
	end

	assign data_miss_to_cache  = to_cache_r;
	assign data_miss_to_memory = to_mem_r;

endmodule : cache_control_unit

`default_nettype wire

/* cache_ctl_if.sv */
// Link between the cache control register and the controller that drives it.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface cache_ctl_if;
	logic        req;
	logic        write;
	logic [31:0] addr;
	logic [1:0]  size;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;
	logic        err;

	modport dev  (input req, write, addr, size, wdata, output rdata, ack, err);
	modport host (output req, write, addr, size, wdata, input rdata, ack, err);
endinterface : cache_ctl_if

`default_nettype wire

/* cache_ctl_master.sv */
// Controller end: takes orders over APB and issues accesses on the link.
// Assumes the APB master and the link share pclk.
`timescale 1ns/100ps
`default_nettype none

module cache_ctl_master
	import cache_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Register access link
	cache_ctl_if.host        bus
);
	import cache_ctl_pkg::*;

	logic [31:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic        pend_r;
	logic        write_r;
	logic [1:0]  size_r;
	logic        done_r;
	logic        err_r;
	logic        acc;
	logic        wr;
	logic        mapped;
	logic        go;
	logic        fin;

	// ==========================================================
	// APB decode; zero wait states
	assign acc    = psel && penable;
	assign wr     = acc && pwrite;
	assign mapped = (paddr == OFS_WDATA) || (paddr == OFS_CMD) || (paddr == OFS_STATUS)
		|| (paddr == OFS_RDATA) || (paddr == OFS_ADDR);
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	// Orders while one is pending are dropped; software polls the pending bit
	assign go  = wr && (paddr == OFS_CMD) && pwdata[CMD_GO_BIT] && !pend_r;
	assign fin = pend_r && bus.ack;

	always_comb
	begin
		prdata = 32'h00000000;
		if (acc && !pwrite)
		begin
			case (paddr)
				OFS_WDATA:  prdata = {16'h0000, wdata_r};
				OFS_CMD:    prdata = {28'h0000000, size_r, write_r, 1'b0};
				OFS_STATUS: prdata = {29'h00000000, err_r, done_r, pend_r};
				OFS_RDATA:  prdata = {16'h0000, rdata_r};
				OFS_ADDR:   prdata = addr_r;
				default:    prdata = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Order registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_r  <= CTRL_ADDR;
			wdata_r <= 16'h0000;
			write_r <= 1'b0;
			size_r  <= SIZE_HALF;
		end
		else
		begin
			if (wr && (paddr == OFS_ADDR) && !pend_r)
				addr_r <= pwdata;
			if (wr && (paddr == OFS_WDATA) && !pend_r)
				wdata_r <= pwdata[15:0];
			if (go)
			begin
				write_r <= pwdata[CMD_WR_BIT];
				size_r  <= pwdata[CMD_SZ_LSB +: 2];
			end
		end
	end

	// ==========================================================
	// Link request and sticky status; a completion beats a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_r  <= 1'b0;
			done_r  <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			if (go)
				pend_r <= 1'b1;
			else if (fin)
				pend_r <= 1'b0;
			if (fin)
			begin
				done_r <= 1'b1;
				err_r  <= bus.err;                                     // RQ1
				if (!write_r)
					rdata_r <= bus.rdata;
			end
			else if (wr && (paddr == OFS_STATUS))
			begin
				if (pwdata[ST_DONE_BIT])
					done_r <= 1'b0;
				if (pwdata[ST_ERR_BIT])
					err_r <= 1'b0;
			end
		end
	end

	assign bus.req   = pend_r;
	assign bus.write = write_r;
	assign bus.addr  = addr_r;
	assign bus.size  = size_r;
	assign bus.wdata = wdata_r;

endmodule : cache_ctl_master

`default_nettype wire

/* cache_ctl_pkg.sv */
// Constants shared by both ends of the cache control link.
// Assumes one clock, pclk, and an active-low asynchronous reset.
//
// Notes on behaviour
// (RQ1) Control register: 16 bits, half-word access only
// (RQ2) Data way bits suppress refill per way
// (RQ3) Instruction way bits suppress refill per way
// (RQ4) Write-back: alloc bit picks cache or memory
// (RQ5) Write-through forces no-allocate on write miss
// (RQ6) Policy bit: 0 write-back, 1 write-through
// (RQ7) Data invalidate clears all valid flags, reads 0
// (RQ8) Instr invalidate clears all valid flags, reads 0
// (RQ9) Data busy flag, read-only, polled by software
// (RQ10) Instr busy flag, read-only, polled by software
// (RQ11) Data cache enable, resets to 0
// (RQ12) Instruction cache enable, resets to 0
// (RQ13) Software programs and invalidates before use
// (RQ14) Busy reads 1 throughout an invalidate sweep

package cache_ctl_pkg;

	// ==========================================================
	// Control register location and access size
	localparam logic [31:0] CTRL_ADDR   = 32'hC0000070;
	localparam logic [1:0]  SIZE_BYTE   = 2'h0;
	localparam logic [1:0]  SIZE_HALF   = 2'h1;
	localparam logic [1:0]  SIZE_WORD   = 2'h3;

	// ==========================================================
	// Control register fields
	localparam int          DWAY_LSB    = 12;
	localparam int          IWAY_LSB    = 8;
	localparam int          ALLOC_BIT   = 7;
	localparam int          WPOL_BIT    = 6;
	localparam int          DINV_BIT    = 5;
	localparam int          IINV_BIT    = 4;
	localparam int          DBUSY_BIT   = 3;
	localparam int          IBUSY_BIT   = 2;
	localparam int          DEN_BIT     = 1;
	localparam int          IEN_BIT     = 0;
	localparam logic [15:0] CTRL_RESET  = 16'h0000;
	// Bits that hold state; strobes and busy flags are not stored
	localparam logic [15:0] CTRL_STORED = 16'hFFC3;

	// ==========================================================
	// Cache geometry
	localparam int          NUM_WAYS    = 4;
	localparam int          NUM_ENTRIES = 256;
	localparam int          IDX_W       = 8;

	// ==========================================================
	// Controller APB register map
	localparam logic [11:0] OFS_WDATA   = 12'h000;
	localparam logic [11:0] OFS_CMD     = 12'h004;
	localparam logic [11:0] OFS_STATUS  = 12'h008;
	localparam logic [11:0] OFS_RDATA   = 12'h00C;
	localparam logic [11:0] OFS_ADDR    = 12'h010;
	localparam int          CMD_GO_BIT  = 0;
	localparam int          CMD_WR_BIT  = 1;
	localparam int          CMD_SZ_LSB  = 2;
	localparam int          ST_PEND_BIT = 0;
	localparam int          ST_DONE_BIT = 1;
	localparam int          ST_ERR_BIT  = 2;

endpackage : cache_ctl_pkg

/* cache_ctl_sva.sv */
// Checker for the register link between the controller and the cache control unit.
// Assumes one clock, pclk, and the active-low reset presetn.
`timescale 1ns/100ps
`default_nettype none

module cache_ctl_sva
	import cache_ctl_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Link
	input wire logic        req,
	input wire logic        write,
	input wire logic [31:0] addr,
	input wire logic [1:0]  size,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        ack,
	input wire logic        err
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic        take;
	logic        ok;
	logic [15:0] shadow_r;
	logic [7:0]  dsw_r;
	logic [7:0]  isw_r;

	assign take = req && !ack;
	assign ok   = addr == CTRL_ADDR && size == SIZE_HALF;

	// ====
	// Mirror of stored bits and sweep windows, so reads can be judged here
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			shadow_r <= CTRL_RESET;
		else if (ack && write && !err)
			shadow_r <= wdata & CTRL_STORED;

	// Counts the cycles of the sweep still to run after the write answer
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			dsw_r <= 8'h00;
		else if (ack && write && !err && wdata[DINV_BIT])
			dsw_r <= 8'hFF;
		else if (dsw_r != 8'h00)
			dsw_r <= dsw_r - 8'h01;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			isw_r <= 8'h00;
		else if (ack && write && !err && wdata[IINV_BIT])
			isw_r <= 8'hFF;
		else if (isw_r != 8'h00)
			isw_r <= isw_r - 8'h01;

	// ====
	// Properties
	property p_answer; take |=> ack; endproperty
	a_answer: assert property (p_answer) else $error("no answer after take");
	property p_pulse; ack |=> !ack; endproperty
	a_pulse: assert property (p_pulse) else $error("ack held too long");
	property p_stray; !req |=> !ack; endproperty
	a_stray: assert property (p_stray) else $error("ack without request");
	property p_hold; take |=> req && $stable(addr) && $stable(write) && $stable(wdata); endproperty
	a_hold: assert property (p_hold) else $error("request dropped before ack");
	property p_bad; take && !ok |=> err; endproperty
	a_bad: assert property (p_bad) else $error("bad access not refused");
	property p_good; take && ok |=> !err; endproperty
	a_good: assert property (p_good) else $error("good access refused");
	property p_err_ack; err |-> ack; endproperty
	a_err_ack: assert property (p_err_ack) else $error("err outside ack");
	property p_wr_zero; ack && (write || err) |-> rdata == 16'h0000; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data not zero");
	property p_dinv0; ack && !write |-> !rdata[DINV_BIT]; endproperty
	a_dinv0: assert property (p_dinv0) else $error("data invalidate reads one");
	property p_iinv0; ack && !write |-> !rdata[IINV_BIT]; endproperty
	a_iinv0: assert property (p_iinv0) else $error("instr invalidate reads one");
	property p_back; ack && !write && !err |-> (rdata & CTRL_STORED) == shadow_r; endproperty
	a_back: assert property (p_back) else $error("stored bits differ");
	property p_dbusy; take && ok && !write && dsw_r != 8'h00 |=> rdata[DBUSY_BIT]; endproperty
	a_dbusy: assert property (p_dbusy) else $error("data busy low in sweep");
	property p_ibusy; take && ok && !write && isw_r != 8'h00 |=> rdata[IBUSY_BIT]; endproperty
	a_ibusy: assert property (p_ibusy) else $error("instr busy low in sweep");
endmodule : cache_ctl_sva

`default_nettype wire

/* testbench.sv */
// Bench: APB drives the controller, which reaches the cache control unit over the link.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import cache_ctl_pkg::*;

	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic	instr_activity, instr_refill_req, instr_refill_grant, instr_inv_clear;
	logic	data_activity, data_refill_req, data_refill_grant, data_inv_clear;
	logic	data_write_miss, data_miss_to_cache, data_miss_to_memory;
	logic	instr_cache_enable, data_cache_enable, instr_cache_busy, data_cache_busy;
	logic	data_write_policy, data_write_miss_alloc_mode, perr;
	logic [1:0]	instr_refill_way, data_refill_way;
	logic [3:0]	instr_way_refill_inhibit, data_way_refill_inhibit;
	logic [7:0]	instr_inv_index, data_inv_index;
	logic [15:0]	v, q;
	integer	fail_count, total_checks, seed, dn, ds, jn, js;

	cache_ctl_if link();
	cache_control_unit u_cache_control_unit (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.bus                        (link.dev),
		.instr_cache_enable         (instr_cache_enable),
		.instr_way_refill_inhibit   (instr_way_refill_inhibit),
		.instr_activity             (instr_activity),
		.instr_refill_req           (instr_refill_req),
		.instr_refill_way           (instr_refill_way),
		.instr_refill_grant         (instr_refill_grant),
		.instr_inv_clear            (instr_inv_clear),
		.instr_inv_index            (instr_inv_index),
		.data_cache_enable          (data_cache_enable),
		.data_way_refill_inhibit    (data_way_refill_inhibit),
		.data_write_policy          (data_write_policy),
		.data_write_miss_alloc_mode (data_write_miss_alloc_mode),
		.data_activity              (data_activity),
		.data_refill_req            (data_refill_req),
		.data_refill_way            (data_refill_way),
		.data_refill_grant          (data_refill_grant),
		.data_write_miss            (data_write_miss),
		.data_miss_to_cache         (data_miss_to_cache),
		.data_miss_to_memory        (data_miss_to_memory),
		.data_inv_clear             (data_inv_clear),
		.data_inv_index             (data_inv_index),
		.instr_cache_busy           (instr_cache_busy),
		.data_cache_busy            (data_cache_busy)
	);
	cache_ctl_master u_cache_ctl_master (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (link.host)
	);
	cache_ctl_sva u_cache_ctl_sva (.pclk(pclk), .presetn(presetn), .req(link.req),
		.write(link.write), .addr(link.addr), .size(link.size), .wdata(link.wdata),
		.rdata(link.rdata), .ack(link.ack), .err(link.err));

	always #12.5 pclk = ~pclk;

	// Sweep monitor: count and index sum prove every entry was cleared once
	always @(posedge pclk)
	begin
		if (data_inv_clear === 1'b1)
		begin
			dn++;
			ds += data_inv_index;
		end
		if (instr_inv_clear === 1'b1)
		begin
			jn++;
			js += instr_inv_index;
		end
	end

	// ====
	// Checks and bus cycles
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	function automatic logic exp_err(input logic [31:0] a, input logic [1:0] sz);
		return !(a == CTRL_ADDR && sz == SIZE_HALF);
	endfunction : exp_err

	function automatic logic exp_alloc(input logic [15:0] c);
		return c[DEN_BIT] && !c[WPOL_BIT] && !c[ALLOC_BIT];
	endfunction : exp_alloc

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		chk("pready", 1'b1, pready);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic xfer(input logic wr, input logic [31:0] a, input logic [1:0] sz,
		input logic [15:0] d, output logic [15:0] r);
		logic [31:0] s;
		int n;
		apb(1'b1, OFS_ADDR, a, s);
		apb(1'b1, OFS_WDATA, {16'h0000, d}, s);
		apb(1'b1, OFS_CMD, {28'h0000000, sz, wr, 1'b1}, s);
		n = 0;
		do
		begin
			apb(1'b0, OFS_STATUS, 32'h0, s);
			n++;
		end
		while (s[ST_PEND_BIT] !== 1'b0 && n < 20);
		chk("pending", 1'b0, s[ST_PEND_BIT]);
		chk("link err", exp_err(a, sz), s[ST_ERR_BIT]);
		apb(1'b0, OFS_RDATA, 32'h0, s);
		r = s[15:0];
		apb(1'b1, OFS_STATUS, 32'h6, s);
	endtask : xfer

	// Port levels, refill grants per way and write-miss steering for setting c
	task automatic chk_ports(input logic [15:0] c);
		chk("dway", c[15:12], data_way_refill_inhibit);
		chk("iway", c[11:8], instr_way_refill_inhibit);
		chk("alloc", c[ALLOC_BIT], data_write_miss_alloc_mode);
		chk("policy", c[WPOL_BIT], data_write_policy);
		chk("den", c[DEN_BIT], data_cache_enable);
		chk("ien", c[IEN_BIT], instr_cache_enable);
		for (int w = 0; w < 4; w++)
		begin
			data_refill_req <= 1'b1;
			data_refill_way <= 2'(w);
			instr_refill_req <= 1'b1;
			instr_refill_way <= 2'(w);
			data_write_miss <= 1'b1;
			@(posedge pclk);
			data_refill_req <= 1'b0;
			instr_refill_req <= 1'b0;
			data_write_miss <= 1'b0;
			@(posedge pclk);
			chk("dgrant", c[DEN_BIT] & !c[DWAY_LSB+w], data_refill_grant);
			chk("igrant", c[IEN_BIT] & !c[IWAY_LSB+w], instr_refill_grant);
			chk("to_cache", exp_alloc(c), data_miss_to_cache);
			chk("to_mem", !exp_alloc(c), data_miss_to_memory);
		end
	endtask : chk_ports

	// ====
	// Main sequence
	initial
	begin
		logic [15:0] corner [3];
		logic [31:0] s;
		corner = '{16'h0002, 16'h0042, 16'h0082};
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{instr_activity, instr_refill_req, instr_refill_way} = '0;
		{data_activity, data_refill_req, data_refill_way, data_write_miss} = '0;
		{fail_count, total_checks, dn, ds, jn, js} = '0;
		seed = 32'hA197;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
		chk("reset value", CTRL_RESET, q);
		chk_ports(CTRL_RESET);
		apb(1'b0, 12'h020, 32'h0, s);
		chk("unmapped", 1'b1, perr);
		for (int i = 0; i < 14; i++)
		begin
			v = (i < 3) ? corner[i] : 16'($random(seed));
			v[DINV_BIT] = 1'b0;
			v[IINV_BIT] = 1'b0;
			xfer(1'b1, CTRL_ADDR, SIZE_HALF, v, q);
			chk_ports(v);
			xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
			chk("readback", v & CTRL_STORED, q);
		end
		// Refused shapes must leave the register alone
		xfer(1'b1, CTRL_ADDR, SIZE_BYTE, ~v, q);
		xfer(1'b1, CTRL_ADDR, SIZE_WORD, ~v, q);
		xfer(1'b1, CTRL_ADDR + 32'h2, SIZE_HALF, ~v, q);
		xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
		chk("after refusal", v & CTRL_STORED, q);
		data_activity <= 1'b1;
		instr_activity <= 1'b1;
		xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
		chk("busy by activity", 2'b11, q[3:2]);
		data_activity <= 1'b0;
		instr_activity <= 1'b0;
		{dn, ds, jn, js} = '0;
		xfer(1'b1, CTRL_ADDR, SIZE_HALF, 16'h0030 | v, q);
		xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
		chk("strobes read", 2'b00, q[5:4]);
		chk("busy in sweep", 2'b11, q[3:2]);
		chk("busy pins in sweep", 2'b11, {data_cache_busy, instr_cache_busy});
		for (int n = 0; n < 400 && (data_cache_busy !== 1'b0 || instr_cache_busy !== 1'b0); n++)
			@(posedge pclk);
		chk("busy pins after sweep", 2'b00, {data_cache_busy, instr_cache_busy});
		chk("data sweep count", 256, dn);
		chk("data index sum", 32640, ds);
		chk("instr sweep count", 256, jn);
		chk("instr index sum", 32640, js);
		xfer(1'b0, CTRL_ADDR, SIZE_HALF, 16'h0000, q);
		chk("idle after sweep", v & CTRL_STORED, q);
		apb(1'b0, OFS_ADDR, 32'h0, s);
		chk("addr reg", CTRL_ADDR, s);
		apb(1'b0, OFS_CMD, 32'h0, s);
		chk("cmd reg", {28'h0000000, SIZE_HALF, 2'b00}, s);
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		stop_test();
	end
endmodule : testbench

`default_nettype wire
